// [pkg/iers_pkg.sv]
package iers_pkg;
    // register map
    localparam logic [3:0] ADDR_RESET_CAUSE_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_MODE = 4'h1;
    localparam logic [3:0] ADDR_STAT = 4'h2;
    // reset_control fields
    localparam int BIT_PRIO = 7;
    localparam int BIT_RI = 4;
    localparam int BIT_TO = 3;
    localparam int BIT_PD = 2;
    localparam int BIT_POR = 1;
    localparam int BIT_BOR = 0;
    localparam logic [7:0] RESET_CAUSE_CONTROL_POR_VAL = 8'h1c;
    localparam logic [7:0] RESET_CAUSE_CONTROL_IMPL_MASK = 8'h9f;
    // mode register fields
    localparam int BIT_IDLE = 0;
    localparam int BIT_CSS_LO = 1;
    localparam int BIT_SOSC_EN = 3;
    localparam int BIT_WDT_EN = 4;
    localparam int BIT_FSCM_EN = 5;
    localparam int BIT_GIE = 6;
    localparam int BIT_EXTCLK = 7;
    localparam logic [1:0] CSS_PRI = 2'h0;
    localparam logic [1:0] CSS_SEC = 2'h1;
    localparam logic [1:0] CSS_PRI_B = 2'h2;
    localparam logic [1:0] CSS_RC = 2'h3;
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int WAKE_DELAY_NS = 1000;
    localparam int WAKE_CYC = (WAKE_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int POWER_UP_TIMER_BITS = 11;
    localparam int RST_FILT_CYC = 4;
    localparam int OST_CYC = 1024;

    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_SLEEP = 6'h02,
        ST_PRIMARY_IDLE = 6'h04,
        ST_SECONDARY_IDLE = 6'h08,
        ST_INTERNAL_OSC_IDLE = 6'h10,
        ST_WAKE = 6'h20
    } iers_state_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic per_clk_en;
        logic pri_osc_en;
        logic rc_osc_en;
        logic pri_running;
        logic sec_running;
        logic branch_vec;
        logic wdt_clear;
    } iers_clk_t;
endpackage

// [rtl/iers_power_up_timer.sv]
`timescale 1ns/1ps
module iers_power_up_timer import iers_pkg::*; #(
    parameter int WIDTH = POWER_UP_TIMER_BITS
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic rc_tick_i,
    input wire logic restart_i,
    input wire logic hold_i,
    output logic busy_o
);
    initial begin
        if (WIDTH < 2 || WIDTH > 16) $error("iers_power_up_timer width unsupported");
    end

    logic [WIDTH-1:0] cnt_r;
    logic run_r;

    // counter restarts on brown-out and waits for supply recovery
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= '0;
            run_r <= 1'b1;
        end else if (ce_i) begin
            if (restart_i || hold_i) begin
                cnt_r <= '0;
                run_r <= 1'b1;
            end else if (run_r && rc_tick_i) begin
                cnt_r <= cnt_r + 1'b1;
                if (&cnt_r) run_r <= 1'b0;
            end
        end
    end

    assign busy_o = run_r;
endmodule // iers_power_up_timer

// [rtl/iers_top.sv]
`timescale 1ns/1ps
module iers_top import iers_pkg::*; #(
    parameter int WAKE_CYCLES = WAKE_CYC,
    parameter int OST_CYCLES = OST_CYC,
    parameter int FILT_CYCLES = RST_FILT_CYC
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic sleep_instr_i,
    input wire logic wdt_clear_instr_i,
    input wire logic reset_instr_i,
    input wire logic irq_flag_i,
    input wire logic irq_enable_i,
    input wire logic wdt_timeout_i,
    input wire logic clk_loss_i,
    input wire logic sosc_ready_i,
    input wire logic pri_ready_i,
    input wire logic rc_tick_i,
    input wire logic brownout_i,
    input wire logic regulator_en_i,
    input wire logic ext_reset_n_i,
    output logic ext_reset_n_o,
    output logic ext_reset_oe_n_o,
    output logic dev_reset_o,
    output logic clk_use_rc_o,
    output iers_clk_t clk_o
);
    // ****************************************************************
    // parameter checks
    // ****************************************************************
    initial begin
        if (WAKE_CYCLES < 1 || WAKE_CYCLES > 255) $error("wake delay out of range");
        if (OST_CYCLES < 1 || OST_CYCLES > 4095) $error("start-up count out of range");
        if (FILT_CYCLES < 1 || FILT_CYCLES > 15) $error("filter count out of range");
    end

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [1:0] external_reset_pin_s_r, bor_s_r, sosc_s_r, pri_s_r, tick_s_r, loss_s_r;
    logic external_reset_pin_q, bor_q, sosc_q, pri_q, tick_q, tick_d_r, loss_q;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            external_reset_pin_s_r <= 2'h3;
            bor_s_r <= 2'h0;
            sosc_s_r <= 2'h0;
            pri_s_r <= 2'h0;
            tick_s_r <= 2'h0;
            loss_s_r <= 2'h0;
            tick_d_r <= 1'b0;
        end else if (ce_i) begin
            external_reset_pin_s_r <= {external_reset_pin_s_r[0], ext_reset_n_i};
            bor_s_r <= {bor_s_r[0], brownout_i};
            sosc_s_r <= {sosc_s_r[0], sosc_ready_i};
            pri_s_r <= {pri_s_r[0], pri_ready_i};
            tick_s_r <= {tick_s_r[0], rc_tick_i};
            loss_s_r <= {loss_s_r[0], clk_loss_i};
            tick_d_r <= tick_s_r[1];
        end
    end
    assign external_reset_pin_q = external_reset_pin_s_r[1];
    assign bor_q = bor_s_r[1];
    assign sosc_q = sosc_s_r[1];
    assign pri_q = pri_s_r[1];
    assign tick_q = tick_s_r[1] & ~tick_d_r;
    assign loss_q = loss_s_r[1];

    // ****************************************************************
    // external reset filter
    // ****************************************************************
    logic [3:0] filt_cnt_r;
    logic external_reset_pin_rst_r;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            filt_cnt_r <= 4'h0;
            external_reset_pin_rst_r <= 1'b0;
        end else if (ce_i) begin
            if (external_reset_pin_q) begin
                filt_cnt_r <= 4'h0;
                external_reset_pin_rst_r <= 1'b0;
            end else if (filt_cnt_r == 4'(FILT_CYCLES)) begin
                external_reset_pin_rst_r <= 1'b1;
            end else begin
                filt_cnt_r <= filt_cnt_r + 4'h1;
            end
        end
    end
    // pin is input only: never driven low
    assign ext_reset_n_o = 1'b1;
    assign ext_reset_oe_n_o = 1'b1;

    // ****************************************************************
    // power-up timer and reset generation
    // ****************************************************************
    logic power_up_timer_busy, bor_rise, bor_d_r, por_done_r;
    logic wdt_rst, rst_any, rst_any_d_r;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bor_d_r <= 1'b0;
            por_done_r <= 1'b0;
            rst_any_d_r <= 1'b1;
        end else if (ce_i) begin
            bor_d_r <= bor_q;
            if (!power_up_timer_busy) por_done_r <= 1'b1;
            rst_any_d_r <= rst_any;
        end
    end
    assign bor_rise = bor_q & ~bor_d_r & regulator_en_i;

    iers_power_up_timer #(.WIDTH(POWER_UP_TIMER_BITS)) u_power_up_timer (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .rc_tick_i(tick_q),
        .restart_i(bor_rise),
        .hold_i(bor_q & regulator_en_i),
        .busy_o(power_up_timer_busy)
    );

    // ****************************************************************
    // power-managed mode machine
    // ****************************************************************
    iers_state_t state_r, state_nxt;
    logic [7:0] mode_r, reset_cause_control_r;
    logic [7:0] wake_cnt_r;
    logic [11:0] ost_cnt_r;
    logic irq_wake_r, irq_wake, wake_ev, asleep, sleep_ok, need_ost;
    logic [1:0] css;

    assign css = mode_r[BIT_CSS_LO+1:BIT_CSS_LO];
    assign asleep = (state_r != ST_RUN) && (state_r != ST_WAKE);
    assign irq_wake = irq_flag_i & irq_enable_i;
    assign wdt_rst = wdt_timeout_i & ~asleep & por_done_r;
    assign rst_any = power_up_timer_busy | external_reset_pin_rst_r | reset_instr_i | wdt_rst;
    assign dev_reset_o = rst_any;
    assign wake_ev = asleep & (irq_wake | wdt_timeout_i);
    // secondary idle needs its oscillator enabled
    assign sleep_ok = !(mode_r[BIT_IDLE] && css == CSS_SEC && !mode_r[BIT_SOSC_EN]);
    assign need_ost = (state_r == ST_SLEEP) && !mode_r[BIT_EXTCLK];

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (sleep_instr_i && sleep_ok) begin
                    if (!mode_r[BIT_IDLE]) state_nxt = ST_SLEEP;
                    else if (css == CSS_SEC) state_nxt = ST_SECONDARY_IDLE;
                    else if (css == CSS_PRI) state_nxt = ST_INTERNAL_OSC_IDLE;
                    else if (css == CSS_RC) state_nxt = ST_INTERNAL_OSC_IDLE;
                    else state_nxt = ST_PRIMARY_IDLE;
                end
            end
            ST_SLEEP, ST_PRIMARY_IDLE, ST_SECONDARY_IDLE, ST_INTERNAL_OSC_IDLE: begin
                if (wake_ev) state_nxt = ST_WAKE;
            end
            ST_WAKE: begin
                if (wake_cnt_r == 8'h0 && ost_cnt_r == 12'h0) state_nxt = ST_RUN;
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= ST_RUN;
        end else if (ce_i) begin
            if (rst_any) state_r <= ST_RUN;
            else state_r <= state_nxt;
        end
    end

    // wake delay and start-up timer, loaded on the wake event
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wake_cnt_r <= 8'h0;
            ost_cnt_r <= 12'h0;
            irq_wake_r <= 1'b0;
        end else if (ce_i) begin
            if (asleep && wake_ev) begin
                wake_cnt_r <= 8'(WAKE_CYCLES - 1);
                ost_cnt_r <= need_ost ? 12'(OST_CYCLES) : 12'h0;
                irq_wake_r <= irq_wake;
            end else if (state_r == ST_WAKE) begin
                if (wake_cnt_r != 8'h0) wake_cnt_r <= wake_cnt_r - 8'h1;
                if (ost_cnt_r != 12'h0 && pri_q) ost_cnt_r <= ost_cnt_r - 12'h1;
            end
        end
    end

    // ****************************************************************
    // clock source control
    // ****************************************************************
    logic exit_by_rst_r, pri_run_r, sec_run_r, rc_run_r;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            exit_by_rst_r <= 1'b1;
            pri_run_r <= 1'b0;
            sec_run_r <= 1'b0;
            rc_run_r <= 1'b0;
        end else if (ce_i) begin
            if (rst_any && (asleep || !por_done_r)) exit_by_rst_r <= 1'b1;
            else if (sleep_instr_i || wr_i) exit_by_rst_r <= 1'b0;
            if (state_nxt == ST_SECONDARY_IDLE && state_r == ST_RUN) begin
                pri_run_r <= 1'b0;
                sec_run_r <= 1'b1;
                rc_run_r <= 1'b0;
            end else if (state_nxt == ST_INTERNAL_OSC_IDLE && state_r == ST_RUN) begin
                pri_run_r <= 1'b0;
                rc_run_r <= 1'b1;
            end else if (state_nxt == ST_SLEEP && state_r == ST_RUN) begin
                pri_run_r <= 1'b0;
                sec_run_r <= 1'b0;
                rc_run_r <= 1'b0;
            end else if (state_r == ST_RUN && !exit_by_rst_r && css[1] == css[0]) begin
                pri_run_r <= (css == CSS_PRI) ? pri_q : 1'b0;
            end else if (state_r == ST_RUN && css == CSS_PRI_B) begin
                pri_run_r <= pri_q;
                rc_run_r <= 1'b0;
            end
        end
    end
    assign clk_use_rc_o = exit_by_rst_r;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clk_o <= '0;
        end else if (ce_i) begin
            clk_o.cpu_clk_en <= !asleep && state_r != ST_WAKE && !rst_any;
            clk_o.per_clk_en <= (state_r == ST_SECONDARY_IDLE) ? sosc_q : (state_r != ST_SLEEP);
            clk_o.pri_osc_en <= state_r == ST_PRIMARY_IDLE || (state_r == ST_RUN && css == CSS_PRI_B)
                || (state_r == ST_WAKE && need_ost);
            clk_o.rc_osc_en <= mode_r[BIT_WDT_EN] | mode_r[BIT_FSCM_EN]
                | (state_r == ST_INTERNAL_OSC_IDLE) | rc_run_r | exit_by_rst_r;
            clk_o.pri_running <= pri_run_r;
            clk_o.sec_running <= sec_run_r;
            clk_o.branch_vec <= (state_r == ST_WAKE) && (state_nxt == ST_RUN)
                && irq_wake_r && mode_r[BIT_GIE];
            clk_o.wdt_clear <= sleep_instr_i | wdt_clear_instr_i
                | (loss_q & mode_r[BIT_FSCM_EN]);
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    logic por_flag;
    assign por_flag = !por_done_r;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_r <= 8'h0;
        end else if (ce_i) begin
            if (wr_i && addr_i == ADDR_MODE) mode_r <= wdata_i;
        end
    end

    // hardware events win over software writes
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reset_cause_control_r <= RESET_CAUSE_CONTROL_POR_VAL;
        end else if (ce_i) begin
            if (wr_i && addr_i == ADDR_RESET_CAUSE_CONTROL) begin
                reset_cause_control_r[BIT_PRIO] <= wdata_i[BIT_PRIO];
                reset_cause_control_r[BIT_RI] <= wdata_i[BIT_RI];
                reset_cause_control_r[BIT_POR] <= wdata_i[BIT_POR];
                reset_cause_control_r[BIT_BOR] <= wdata_i[BIT_BOR];
            end
            if (reset_instr_i) reset_cause_control_r[BIT_RI] <= 1'b0;
            if (sleep_instr_i || wdt_clear_instr_i) reset_cause_control_r[BIT_TO] <= 1'b1;
            if (wdt_timeout_i && por_done_r) reset_cause_control_r[BIT_TO] <= 1'b0;
            if (wdt_clear_instr_i) reset_cause_control_r[BIT_PD] <= 1'b1;
            if (sleep_instr_i || (wake_ev && wdt_timeout_i)) reset_cause_control_r[BIT_PD] <= 1'b0;
            if (external_reset_pin_rst_r && asleep) reset_cause_control_r[BIT_PD] <= 1'b0;
            if (external_reset_pin_rst_r && state_r == ST_RUN && css != CSS_PRI) reset_cause_control_r[BIT_TO] <= 1'b1;
            if (por_flag) reset_cause_control_r[BIT_POR] <= 1'b0;
            if (bor_rise || por_flag) begin
                reset_cause_control_r[BIT_BOR] <= 1'b0;
                reset_cause_control_r[BIT_RI] <= 1'b1;
                reset_cause_control_r[BIT_TO] <= 1'b1;
                reset_cause_control_r[BIT_PD] <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h0;
        end else if (ce_i) begin
            rdata_o <= 8'h0;
            if (rd_i) begin
                case (addr_i)
                    ADDR_RESET_CAUSE_CONTROL: rdata_o <= (reset_cause_control_r & RESET_CAUSE_CONTROL_IMPL_MASK)
                        & {7'h7f, regulator_en_i};
                    ADDR_MODE: rdata_o <= mode_r;
                    ADDR_STAT: rdata_o <= {2'h0, state_r};
                    default: rdata_o <= 8'h0;
                endcase
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sec_entry_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && state_r == ST_RUN && !rst_any && sleep_instr_i && mode_r[BIT_IDLE]
        && css == CSS_SEC && mode_r[BIT_SOSC_EN] |=> state_r == ST_SECONDARY_IDLE)
        else $error("secondary idle not entered");
    sleep_ignored_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && state_r == ST_RUN && !rst_any && sleep_instr_i && mode_r[BIT_IDLE]
        && css == CSS_SEC && !mode_r[BIT_SOSC_EN] |=> state_r == ST_RUN)
        else $error("sleep not ignored");
    rc_entry_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && state_r == ST_RUN && !rst_any && sleep_instr_i && mode_r[BIT_IDLE]
        && css == CSS_PRI |=> state_r == ST_INTERNAL_OSC_IDLE)
        else $error("internal_osc_idle not entered");
    rc_osc_on_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && mode_r[BIT_WDT_EN] |=> clk_o.rc_osc_en)
        else $error("rc oscillator stopped");
    wake_start_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && asleep && irq_wake && !rst_any |=> state_r == ST_WAKE)
        else $error("interrupt did not start exit");
    wake_delay_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && $rose(state_r == ST_WAKE) |-> !clk_o.cpu_clk_en)
        else $error("cpu clocked during wake delay");
    wdt_reset_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        state_r == ST_RUN && wdt_timeout_i && por_done_r |-> dev_reset_o)
        else $error("watchdog reset missing");
    ri_clear_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && reset_instr_i && !bor_rise && !por_flag |=> !reset_cause_control_r[BIT_RI])
        else $error("reset instruction flag not cleared");
    pd_sleep_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && sleep_instr_i && !bor_rise && !por_flag |=> !reset_cause_control_r[BIT_PD])
        else $error("powerdown flag not cleared");
    pin_free_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ext_reset_oe_n_o && ext_reset_n_o)
        else $error("reset pin driven");
endmodule // iers_top

// [bench/iers_far_model.sv]
`timescale 1ns/1ps
// ************
// far side: interrupt source, watchdog, reset pin, rc clock
// ************
module iers_far_model (
    input wire logic clk_i,
    output logic irq_flag_o,
    output logic irq_en_o,
    output logic wdt_to_o,
    output logic pin_low_o,
    output logic rc_tick_o
);
    logic [1:0] div_r = 2'h0;
    initial begin
        irq_flag_o = 1'b0;
        irq_en_o = 1'b0;
        wdt_to_o = 1'b0;
        pin_low_o = 1'b0;
    end
    // rc stand-in: one tick every four reference cycles
    always @(posedge clk_i) begin
        div_r <= div_r + 2'h1;
    end
    assign rc_tick_o = div_r[1];
    // a flag only wakes the device when its enable is set too
    task automatic irq(input logic en, input logic flag);
        @(posedge clk_i);
        irq_en_o <= en;
        irq_flag_o <= flag;
    endtask
    task automatic wdt_fire();
        @(posedge clk_i);
        wdt_to_o <= 1'b1;
        @(posedge clk_i);
        wdt_to_o <= 1'b0;
    endtask
    // open-drain pull of the reset pin; released it sits at the pull-up
    task automatic pin_pull(input int n);
        @(posedge clk_i);
        pin_low_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        pin_low_o <= 1'b0;
    endtask
endmodule // iers_far_model

// [bench/iers_top_tb.sv]
`timescale 1ns/1ps
module iers_top_tb import iers_pkg::*;;
    localparam int WAKE_N = 6;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0, rd = 1'b0, slp = 1'b0, wclr = 1'b0, rsti = 1'b0, bo = 1'b0;
    logic ce = 1'b1, loss = 1'b0, sosc = 1'b1;
    logic [7:0] rdata;
    logic oe_n, pin_o, dres, use_rc, irqf, irqe, wto, pin_low, tick;
    iers_clk_t ck;
    wire pin = ~pin_low & (oe_n | pin_o);
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int br_cnt = 0;
    int wc_cnt = 0;
    int rst_cyc = 0;
    always #50 clk = ~clk;

    iers_top #(.WAKE_CYCLES(WAKE_N), .OST_CYCLES(4), .FILT_CYCLES(4)) DUT (
        .ref_clk_i(clk), .arst_n_i(rst_n), .ce_i(ce), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .sleep_instr_i(slp), .wdt_clear_instr_i(wclr), .reset_instr_i(rsti),
        .irq_flag_i(irqf), .irq_enable_i(irqe), .wdt_timeout_i(wto),
        .clk_loss_i(loss), .sosc_ready_i(sosc), .pri_ready_i(1'b1),
        .rc_tick_i(tick), .brownout_i(bo), .regulator_en_i(1'b1),
        .ext_reset_n_i(pin), .ext_reset_n_o(pin_o), .ext_reset_oe_n_o(oe_n),
        .dev_reset_o(dres), .clk_use_rc_o(use_rc), .clk_o(ck));
    iers_far_model u_far (.clk_i(clk), .irq_flag_o(irqf), .irq_en_o(irqe),
        .wdt_to_o(wto), .pin_low_o(pin_low), .rc_tick_o(tick));

    // ************
    // tasks
    // ************
    task automatic complete_run();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask
    // k: 0 sleep, 1 watchdog clear, 2 reset instruction
    task automatic instr(input int k);
        @(posedge clk);
        slp <= (k == 0);
        wclr <= (k == 1);
        rsti <= (k == 2);
        @(posedge clk);
        {slp, wclr, rsti} <= 3'h0;
        repeat (4) @(posedge clk);
    endtask
    task automatic wait_rel(output int n);
        n = 0;
        while (dres !== 1'b0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20000) begin
            error_cnt++;
            $display("[ERR] reset_release expected 0 seen 1");
        end
    endtask
    task automatic wait_cpu(output int n);
        n = 0;
        while (ck.cpu_clk_en !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) begin
            error_cnt++;
            $display("[ERR] cpu_clk_en expected 1 seen 0");
        end
        repeat (2) @(posedge clk);
    endtask

    always @(posedge clk) begin
        cyc++;
        br_cnt += int'(ck.branch_vec === 1'b1);
        wc_cnt += int'(ck.wdt_clear === 1'b1);
        rst_cyc += int'(dres === 1'b1);
        if (cyc == 90000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ************
    // main sequence
    // ************
    initial begin
        int n;
        int b;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wait_rel(n);
        chk("power_up_timer_len", 8'h01, 8'(n > 8000 && n < 8400));
        rreg(ADDR_RESET_CAUSE_CONTROL, 8'h1c, "reset_cause_control_por");
        rreg(4'h9, 8'h00, "unmapped");
        wreg(ADDR_RESET_CAUSE_CONTROL, 8'hff);
        rreg(ADDR_RESET_CAUSE_CONTROL, 8'h9f, "reset_cause_control_sw");
        wreg(ADDR_MODE, 8'h00);
        b = wc_cnt;
        instr(0);
        chk("wdt_clr", 8'h01, 8'(wc_cnt - b));
        rreg(ADDR_STAT, {2'h0, ST_SLEEP}, "st_sleep");
        chk("sleep_clk", 8'h00, {6'h0, ck.pri_running, ck.sec_running});
        rreg(ADDR_RESET_CAUSE_CONTROL, 8'h9b, "reset_cause_control_slp");
        u_far.irq(1'b0, 1'b1);
        repeat (10) @(posedge clk);
        rreg(ADDR_STAT, {2'h0, ST_SLEEP}, "irq_masked");
        b = br_cnt;
        u_far.irq(1'b1, 1'b1);
        wait_cpu(n);
        u_far.irq(1'b0, 1'b0);
        chk("no_branch", 8'h00, 8'(br_cnt - b));
        instr(1);
        rreg(ADDR_RESET_CAUSE_CONTROL, 8'h9f, "reset_cause_control_clr");
        wreg(ADDR_MODE, 8'h03);
        instr(0);
        rreg(ADDR_STAT, {2'h0, ST_RUN}, "sosc_off");
        sosc <= 1'b0;
        wreg(ADDR_MODE, 8'h0b);
        instr(0);
        rreg(ADDR_STAT, {2'h0, ST_SECONDARY_IDLE}, "st_sec");
        chk("sosc_wait", 8'h00, {7'h0, ck.per_clk_en});
        sosc <= 1'b1;
        repeat (4) @(posedge clk);
        chk("sec_clk", 8'h09, {3'h0, ck.cpu_clk_en, ck.per_clk_en, ck.pri_osc_en,
            ck.pri_running, ck.sec_running});
        // a watchdog pulse while the clock enable is low must be lost
        ce <= 1'b0;
        u_far.wdt_fire();
        ce <= 1'b1;
        rreg(ADDR_STAT, {2'h0, ST_SECONDARY_IDLE}, "ce_freeze");
        u_far.wdt_fire();
        wait_cpu(n);
        chk("wake_dly", 8'h01, 8'(n >= WAKE_N && n <= WAKE_N + 4));
        chk("wdt_wake", 8'h03, {6'h0, ck.sec_running, ~dres});
        rreg(ADDR_MODE, 8'h0b, "mode_sec");
        rreg(ADDR_RESET_CAUSE_CONTROL, 8'h93, "reset_cause_control_wdt");
        wreg(ADDR_MODE, 8'h51);
        instr(0);
        rreg(ADDR_STAT, {2'h0, ST_INTERNAL_OSC_IDLE}, "st_rc");
        chk("rc_clk", 8'h09, {4'h0, ck.per_clk_en, ck.pri_osc_en, ck.pri_running,
            ck.rc_osc_en});
        b = br_cnt;
        u_far.irq(1'b1, 1'b1);
        wait_cpu(n);
        u_far.irq(1'b0, 1'b0);
        chk("branch", 8'h01, 8'(br_cnt - b));
        rreg(ADDR_MODE, 8'h51, "mode_rc");
        wreg(ADDR_MODE, 8'h61);
        repeat (2) @(posedge clk);
        chk("rc_run", 8'h01, {7'h0, ck.rc_osc_en});
        b = wc_cnt;
        loss <= 1'b1;
        @(posedge clk);
        loss <= 1'b0;
        repeat (4) @(posedge clk);
        chk("loss_clr", 8'h01, 8'(wc_cnt - b));
        b = rst_cyc;
        u_far.wdt_fire();
        repeat (3) @(posedge clk);
        chk("wdt_rst", 8'h01, 8'(rst_cyc - b));
        wait_rel(n);
        rreg(ADDR_RESET_CAUSE_CONTROL, 8'h93, "reset_cause_control_wrst");
        instr(2);
        wait_rel(n);
        rreg(ADDR_RESET_CAUSE_CONTROL, 8'h83, "reset_cause_control_ri");
        b = rst_cyc;
        u_far.pin_pull(2);
        repeat (8) @(posedge clk);
        chk("glitch", 8'h00, 8'(rst_cyc - b));
        u_far.pin_pull(20);
        chk("pin_rst", 8'h03, {6'h0, dres, oe_n});
        wait_rel(n);
        wreg(ADDR_MODE, 8'h00);
        wreg(ADDR_RESET_CAUSE_CONTROL, 8'h7f);
        instr(0);
        @(posedge clk);
        bo <= 1'b1;
        repeat (20) @(posedge clk);
        bo <= 1'b0;
        repeat (6000) @(posedge clk);
        bo <= 1'b1;
        repeat (10) @(posedge clk);
        bo <= 1'b0;
        wait_rel(n);
        chk("power_up_timer_restart", 8'h01, 8'(n > 4096));
        chk("rc_forced", 8'h01, {7'h0, use_rc});
        rreg(ADDR_RESET_CAUSE_CONTROL, 8'h1e, "reset_cause_control_bor");
        complete_run();
    end
endmodule // iers_top_tb
